// file: core/rx_pkg.sv
// Constants shared by the oversampling receive front end and its testbench.
// Assumes a single core clock and an AXI4-Lite master for register access.
package rx_pkg;

    // -------------------------------------------------------------------
    // Register map (byte addresses) and bus answers
    // -------------------------------------------------------------------
    localparam logic [7:0] REG_DATA = 8'h00;
    localparam logic [7:0] REG_CTRL = 8'h04;
    localparam logic [7:0] REG_DIV = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_MASK = 8'h10;
    localparam logic [7:0] REG_STATE = 8'h14;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // -------------------------------------------------------------------
    // Field positions and reset values
    // -------------------------------------------------------------------
    localparam int CTL_EN = 0;
    localparam int CTL_SLEEP = 1;
    localparam int NUM_FLAGS = 6;
    localparam int FL_FULL = 0;
    localparam int FL_IDLE = 1;
    localparam int FL_OVR = 2;
    localparam int FL_NOISE = 3;
    localparam int FL_FE = 4;
    localparam int FL_BRK = 5;
    localparam logic [1:0] CTL_RESET = 2'h0;
    // Core clocks per oversample tick; 40 MHz / 21 / 16 is near 115200 Bd.
    localparam logic [15:0] DIV_RESET = 16'h0015;

    // -------------------------------------------------------------------
    // Oversample phases and frame counts
    // -------------------------------------------------------------------
    localparam logic [4:0] PH_FIRST = 5'h01;
    localparam logic [4:0] PH_V1 = 5'h03;
    localparam logic [4:0] PH_V2 = 5'h05;
    localparam logic [4:0] PH_V3 = 5'h07;
    localparam logic [4:0] PH_D1 = 5'h08;
    localparam logic [4:0] PH_D2 = 5'h09;
    localparam logic [4:0] PH_D3 = 5'h0A;
    localparam logic [4:0] PH_FORCE = 5'h0E;
    localparam logic [4:0] PH_LAST = 5'h10;
    localparam logic [3:0] BIT_FIRST = 4'h1;
    localparam logic [3:0] BIT_STOP = 4'h9;
    // One character time of ten bits, in oversample ticks.
    localparam logic [7:0] IDLE_TICKS = 8'hA0;

    typedef enum logic [1:0] {ST_HUNT, ST_START, ST_DATA, ST_TAIL} rx_state_e;

endpackage

// file: core/rx_tick_div.sv
// Divider that turns the core clock into the sixteen-times oversample tick.
// Assumes the divisor comes from a register on the same clock.
`timescale 1ns/1ps
`default_nettype none
module rx_tick_div (
    input wire logic i_clk,
    input wire logic i_rstn,
    input wire logic i_run,
    input wire logic [15:0] i_divisor,
    output logic o_tick
);
    logic [15:0] cnt_r;

    // A divisor of zero or one gives a tick on every core clock.
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            cnt_r <= 16'h0000;
            o_tick <= 1'b0;
        end else if (!i_run) begin
            cnt_r <= 16'h0000;
            o_tick <= 1'b0;
        end else if (cnt_r == 16'h0000) begin
            cnt_r <= (i_divisor == 16'h0000) ? 16'h0000 : i_divisor - 16'h0001;
            o_tick <= 1'b1;
        end else begin
            cnt_r <= cnt_r - 16'h0001;
            o_tick <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: core/rx_front.sv
// Oversampling receive front end with AXI4-Lite registers and interrupt.
// Assumes I_RXD is asynchronous to I_REF_CLK and idles high.
//
// The register addresses and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// R01: Line is sampled at sixteen ticks per bit, phases numbered one to sixteen.
// R02: Start-bit hunt begins when enabled and again after each ending stop bit.
// R03: Start is tentative when a low sample follows three high samples.
// R04: Phase is held at one while hunting, then advances one per sample.
// R05: Two or more highs among phases 3, 5, 7 reject the start.
// R06: Every bit is decided by majority of phase 8, 9, 10 samples.
// R07: Any disagreeing sample in a bit time sets the working noise bit.
// R08: An accepted start bit is always taken as zero.
// R09: Character end loads the buffer, sets full, and noise if seen.
// R10: Phase wraps sixteen to one, keeping misalignment until an edge realigns.
// R11: A valid falling edge pattern inside a frame realigns the phase; the code does so only in data and stop bits, outside phases 8 to 10.
// R12: Non-break framing error forces highs at phases 14, 15, 16 of stop.
// R13: Framing error with all-zero data is a break; no highs are forced.
// R14: Character ready while buffer full sets overrun, keeps old character.
// R15: While sleep is set no receive status flag may become set.
// R16: A low stop-bit majority flags a framing error with the full flag.
// R17: The remote transmitter keeps its rate close enough for mid-bit samples.
module rx_front
    import rx_pkg::*;
(
    input wire logic I_REF_CLK,
    input wire logic I_RSTN,
    input wire logic I_RXD,
    input wire logic I_AWVALID,
    output logic O_AWREADY,
    input wire logic [7:0] I_AWADDR,
    input wire logic I_WVALID,
    output logic O_WREADY,
    input wire logic [31:0] I_WDATA,
    input wire logic [3:0] I_WSTRB,
    output logic O_BVALID,
    input wire logic I_BREADY,
    output logic [1:0] O_BRESP,
    input wire logic I_ARVALID,
    output logic O_ARREADY,
    input wire logic [7:0] I_ARADDR,
    output logic O_RVALID,
    input wire logic I_RREADY,
    output logic [31:0] O_RDATA,
    output logic [1:0] O_RRESP,
    output logic O_IRQ
);
    function automatic logic maj3(input logic a, b, c);
        return (a & b) | (a & c) | (b & c);
    endfunction

    function automatic logic split3(input logic a, b, c);
        return !((a == b) && (b == c));
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return (a == REG_DATA) || (a == REG_CTRL) || (a == REG_DIV) ||
               (a == REG_STATUS) || (a == REG_MASK) || (a == REG_STATE);
    endfunction

    logic [1:0] ctl_r;
    logic [15:0] div_r;
    logic [NUM_FLAGS-1:0] status_r, mask_r, flag_set, flag_clr;
    logic [7:0] rx_data_r, shift_r, shift_nxt;
    logic sync1_r, rx_s, tick;
    logic [15:0] hist_r;
    rx_state_e state_r, state_nxt;
    logic [4:0] phase_r, phase_nxt;
    logic [3:0] bit_idx_r, bit_idx_nxt;
    logic [1:0] ver_ones_r, ver_ones_nxt, ones_total;
    logic [1:0] smp_r, smp_nxt;
    logic noise_r, noise_nxt, force_one, bit_val;
    logic resync, xfer, stop_bad, brk;
    logic [9:0] win;
    logic [7:0] idle_cnt_r;
    logic busy_r;
    logic aw_held_r, w_held_r, wr_en;
    logic [7:0] aw_addr_r;
    logic [31:0] w_data_r, rd_c;
    logic [3:0] w_strb_r;

    // -------------------------------------------------------------------
    // Line synchroniser and oversample tick
    // -------------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            sync1_r <= 1'b1;
            rx_s <= 1'b1;
        end else begin
            sync1_r <= I_RXD;
            rx_s <= sync1_r;
        end
    end

    rx_tick_div u_div (
        .i_clk(I_REF_CLK),
        .i_rstn(I_RSTN),
        .i_run(ctl_r[CTL_EN]),
        .i_divisor(div_r),
        .o_tick(tick) // R01
    );

    // -------------------------------------------------------------------
    // Start hunt, bit sampling and framing
    // -------------------------------------------------------------------
    // Last ten samples with the current one; the current one is phase 7.
    assign win = {hist_r[8:0], rx_s};
    assign ones_total = ver_ones_r + {1'b0, rx_s};
    assign bit_val = maj3(smp_r[1], smp_r[0], rx_s); // R06
    assign stop_bad = !bit_val; // R16
    assign brk = stop_bad && (shift_r == 8'h00); // R13
    assign xfer = tick && (state_r == ST_DATA) && (bit_idx_r == BIT_STOP) &&
                  (phase_r == PH_D3);
    // Realigning during phases 8 to 10 would vote one bit twice, so an
    // edge seen there is left for the ordinary wrap.
    assign resync = (state_r == ST_DATA) && win[9:7] == 3'h7 && !win[6] &&
                    ({1'b0, win[4]} + {1'b0, win[2]} + {1'b0, win[0]} <=
                     2'h1) && (phase_r < PH_D1 || phase_r > PH_D3); // R11

    always_comb begin
        state_nxt = state_r;
        phase_nxt = (phase_r == PH_LAST) ? PH_FIRST : phase_r + 5'h01; // R10
        bit_idx_nxt = bit_idx_r;
        ver_ones_nxt = ver_ones_r;
        smp_nxt = smp_r;
        noise_nxt = noise_r;
        shift_nxt = shift_r;
        force_one = 1'b0;
        if (phase_r == PH_D1) smp_nxt[1] = rx_s;
        if (phase_r == PH_D2) smp_nxt[0] = rx_s;
        case (state_r)
            ST_HUNT: begin
                phase_nxt = PH_FIRST; // R04
                ver_ones_nxt = 2'h0;
                noise_nxt = 1'b0;
                bit_idx_nxt = 4'h0;
                if (hist_r[2:0] == 3'h7 && !rx_s) begin // R03
                    state_nxt = ST_START;
                    phase_nxt = PH_FIRST + 5'h01;
                end
            end
            ST_START: begin
                if (phase_r == PH_V1 || phase_r == PH_V2) begin
                    ver_ones_nxt = ones_total;
                end
                if (phase_r == PH_V3) begin
                    if (ones_total >= 2'h2) begin // R05
                        state_nxt = ST_HUNT;
                        phase_nxt = PH_FIRST;
                    end else if (ones_total != 2'h0) begin
                        noise_nxt = 1'b1; // R07
                    end
                end
                // The start bit is zero whatever its mid samples say.
                if (phase_r == PH_D3 && (smp_r != 2'h0 || rx_s)) begin
                    noise_nxt = 1'b1; // R07 R08
                end
                if (phase_r == PH_LAST) begin
                    state_nxt = ST_DATA;
                    bit_idx_nxt = BIT_FIRST;
                end
            end
            ST_DATA: begin
                if (phase_r == PH_D3) begin
                    if (split3(smp_r[1], smp_r[0], rx_s)) noise_nxt = 1'b1; // R07
                    if (bit_idx_r != BIT_STOP) begin
                        shift_nxt = {bit_val, shift_r[7:1]};
                    end else if (stop_bad && !brk) begin
                        state_nxt = ST_TAIL;
                    end else begin
                        state_nxt = ST_HUNT; // R02
                        phase_nxt = PH_FIRST;
                    end
                end
                if (phase_r == PH_LAST) bit_idx_nxt = bit_idx_r + 4'h1;
                if (resync) begin
                    phase_nxt = PH_D1; // R11
                    if (phase_r > PH_D3) bit_idx_nxt = bit_idx_r + 4'h1;
                end
            end
            ST_TAIL: begin
                force_one = (phase_r >= PH_FORCE); // R12
                if (phase_r == PH_LAST) begin
                    state_nxt = ST_HUNT;
                    phase_nxt = PH_FIRST;
                end
            end
            default: state_nxt = ST_HUNT;
        endcase
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            state_r <= ST_HUNT;
            phase_r <= PH_FIRST;
            bit_idx_r <= 4'h0;
            ver_ones_r <= 2'h0;
            smp_r <= 2'h0;
            noise_r <= 1'b0;
            shift_r <= 8'h00;
            hist_r <= 16'h0000;
        end else if (!ctl_r[CTL_EN]) begin
            state_r <= ST_HUNT; // R02
            phase_r <= PH_FIRST;
            hist_r <= 16'h0000;
        end else if (tick) begin
            state_r <= state_nxt;
            phase_r <= phase_nxt;
            bit_idx_r <= bit_idx_nxt;
            ver_ones_r <= ver_ones_nxt;
            smp_r <= smp_nxt;
            noise_r <= noise_nxt;
            shift_r <= shift_nxt;
            hist_r <= {hist_r[14:0], force_one | rx_s}; // R11 R12
        end
    end

    // -------------------------------------------------------------------
    // Idle line detection
    // -------------------------------------------------------------------
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            idle_cnt_r <= 8'h00;
            busy_r <= 1'b0;
        end else if (tick) begin
            if (!rx_s) begin
                idle_cnt_r <= 8'h00;
                busy_r <= 1'b1;
            end else if (idle_cnt_r == IDLE_TICKS - 8'h01) begin
                idle_cnt_r <= 8'h00;
                busy_r <= 1'b0;
            end else begin
                idle_cnt_r <= idle_cnt_r + 8'h01;
            end
        end
    end

    // -------------------------------------------------------------------
    // Status flags, buffer and interrupt
    // -------------------------------------------------------------------
    always_comb begin
        flag_set = '0;
        if (!ctl_r[CTL_SLEEP]) begin // R15
            flag_set[FL_FULL] = xfer && !status_r[FL_FULL]; // R09
            flag_set[FL_OVR] = xfer && status_r[FL_FULL]; // R14
            flag_set[FL_NOISE] = flag_set[FL_FULL] && noise_nxt; // R09
            flag_set[FL_FE] = flag_set[FL_FULL] && stop_bad; // R16
            flag_set[FL_BRK] = flag_set[FL_FULL] && brk; // R13
            flag_set[FL_IDLE] = tick && rx_s && busy_r &&
                                idle_cnt_r == IDLE_TICKS - 8'h01;
        end
    end

    assign flag_clr = (wr_en && aw_addr_r == REG_STATUS && w_strb_r[0]) ?
                      w_data_r[NUM_FLAGS-1:0] : '0;

    // A flag raised in the cycle it is cleared stays set.
    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            status_r <= '0;
            rx_data_r <= 8'h00;
            O_IRQ <= 1'b0;
        end else begin
            status_r <= (status_r & ~flag_clr) | flag_set;
            if (flag_set[FL_FULL]) rx_data_r <= shift_r; // R09 R14
            O_IRQ <= |(status_r & mask_r);
        end
    end

    // -------------------------------------------------------------------
    // AXI4-Lite slave
    // -------------------------------------------------------------------
    assign wr_en = aw_held_r && w_held_r;

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_AWREADY <= 1'b1;
            O_WREADY <= 1'b1;
            O_BVALID <= 1'b0;
            O_BRESP <= RESP_OKAY;
            aw_held_r <= 1'b0;
            w_held_r <= 1'b0;
            aw_addr_r <= 8'h00;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
        end else begin
            if (O_AWREADY && I_AWVALID) begin
                aw_addr_r <= I_AWADDR;
                aw_held_r <= 1'b1;
                O_AWREADY <= 1'b0;
            end
            if (O_WREADY && I_WVALID) begin
                w_data_r <= I_WDATA;
                w_strb_r <= I_WSTRB;
                w_held_r <= 1'b1;
                O_WREADY <= 1'b0;
            end
            if (wr_en) begin
                aw_held_r <= 1'b0;
                w_held_r <= 1'b0;
                O_BVALID <= 1'b1;
                O_BRESP <= addr_ok(aw_addr_r) ? RESP_OKAY : RESP_SLVERR;
            end
            if (O_BVALID && I_BREADY) begin
                O_BVALID <= 1'b0;
                O_AWREADY <= 1'b1;
                O_WREADY <= 1'b1;
            end
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            ctl_r <= CTL_RESET;
            div_r <= DIV_RESET;
            mask_r <= '0;
        end else if (wr_en) begin
            if (aw_addr_r == REG_CTRL && w_strb_r[0]) begin
                ctl_r <= w_data_r[1:0];
            end else if (aw_addr_r == REG_DIV) begin
                if (w_strb_r[0]) div_r[7:0] <= w_data_r[7:0];
                if (w_strb_r[1]) div_r[15:8] <= w_data_r[15:8];
            end else if (aw_addr_r == REG_MASK && w_strb_r[0]) begin
                mask_r <= w_data_r[NUM_FLAGS-1:0];
            end
        end
    end

    always_comb begin
        rd_c = 32'h00000000;
        if (I_ARADDR == REG_DATA) begin
            rd_c[7:0] = rx_data_r;
        end else if (I_ARADDR == REG_CTRL) begin
            rd_c[1:0] = ctl_r;
        end else if (I_ARADDR == REG_DIV) begin
            rd_c[15:0] = div_r;
        end else if (I_ARADDR == REG_STATUS) begin
            rd_c[NUM_FLAGS-1:0] = status_r;
        end else if (I_ARADDR == REG_MASK) begin
            rd_c[NUM_FLAGS-1:0] = mask_r;
        end else if (I_ARADDR == REG_STATE) begin
            rd_c[4:0] = phase_r;
            rd_c[9:8] = state_r;
            rd_c[15:12] = bit_idx_r;
            rd_c[16] = rx_s;
        end
    end

    always_ff @(posedge I_REF_CLK or negedge I_RSTN) begin
        if (!I_RSTN) begin
            O_ARREADY <= 1'b1;
            O_RVALID <= 1'b0;
            O_RDATA <= 32'h00000000;
            O_RRESP <= RESP_OKAY;
        end else if (O_ARREADY && I_ARVALID) begin
            O_ARREADY <= 1'b0;
            O_RVALID <= 1'b1;
            O_RDATA <= rd_c;
            O_RRESP <= addr_ok(I_ARADDR) ? RESP_OKAY : RESP_SLVERR;
        end else if (O_RVALID && I_RREADY) begin
            O_RVALID <= 1'b0;
            O_ARREADY <= 1'b1;
        end
    end

    // -------------------------------------------------------------------
    // Assertions
    // -------------------------------------------------------------------
    default clocking cb @(posedge I_REF_CLK);
    endclocking
    default disable iff (!I_RSTN);

    sequence s_qualify;
        tick && ctl_r[CTL_EN] && state_r == ST_HUNT &&
        hist_r[2:0] == 3'h7 && !rx_s;
    endsequence

    sequence s_stop_seen;
        xfer && !ctl_r[CTL_SLEEP] && !status_r[FL_FULL];
    endsequence

    a_start_qualify: assert property ( // R03
        s_qualify |=> state_r == ST_START && phase_r == 5'h02)
        else $error("qualified start not taken");
    a_hunt_phase: assert property ( // R04
        state_r == ST_HUNT |-> phase_r == PH_FIRST)
        else $error("phase moved while hunting");
    a_verify_reject: assert property ( // R05
        tick && ctl_r[CTL_EN] && state_r == ST_START && phase_r == PH_V3 &&
        ones_total >= 2'h2 |=> state_r == ST_HUNT)
        else $error("start kept despite two high verify samples");
    a_start_noise: assert property ( // R07
        tick && ctl_r[CTL_EN] && state_r == ST_START && phase_r == PH_D3 &&
        rx_s |=> noise_r)
        else $error("high start sample did not mark noise");
    a_phase_wrap: assert property ( // R10
        tick && ctl_r[CTL_EN] && state_r != ST_HUNT && phase_r == PH_LAST &&
        !resync |=> phase_r == PH_FIRST)
        else $error("phase did not wrap to one");
    a_edge_realign: assert property ( // R11
        tick && ctl_r[CTL_EN] && resync |=> phase_r == PH_D1)
        else $error("falling edge did not realign phase");
    a_tail_forced: assert property ( // R12
        tick && ctl_r[CTL_EN] && state_r == ST_TAIL && phase_r >= PH_FORCE
        |=> hist_r[0])
        else $error("forced high sample missing");
    a_break_hunt: assert property ( // R13
        xfer && ctl_r[CTL_EN] && brk |=> state_r == ST_HUNT)
        else $error("break forced an artificial start edge");
    a_full_noise: assert property ( // R09
        s_stop_seen ##0 noise_nxt |=> status_r[FL_FULL] && status_r[FL_NOISE])
        else $error("noise not flagged with full");
    a_overrun_keep: assert property ( // R14
        xfer && !ctl_r[CTL_SLEEP] && status_r[FL_FULL]
        |=> status_r[FL_OVR] && $stable(rx_data_r))
        else $error("overrun not flagged or buffer overwritten");
    a_sleep_quiet: assert property ( // R15
        ctl_r[CTL_SLEEP] |=> (status_r & ~$past(status_r)) == '0)
        else $error("flag set while sleeping");
    a_stop_framing: assert property ( // R16
        s_stop_seen ##0 stop_bad |=> status_r[FL_FULL] && status_r[FL_FE])
        else $error("low stop bit not flagged");
endmodule
`default_nettype wire

// file: sim/rx_line_src.sv
// Remote transmitter model that sends 8N1 frames onto the serial line.
// Assumes one bit lasts BIT_CLKS core clocks; the line idles high.
`timescale 1ns/1ps
`default_nettype none
module rx_line_src #(
    parameter int BIT_CLKS = 16
) (
    input wire logic i_clk,
    input wire logic i_go,
    input wire logic [7:0] i_char,
    input wire logic i_stop,
    input wire logic i_noise,
    output logic o_line,
    output logic o_busy
);
    int n;
    logic b;
    initial begin
        o_line = 1'b1;
        o_busy = 1'b0;
    end
    always begin
        @(posedge i_clk);
        if (i_go) begin
            o_busy <= 1'b1;
            // A lone low sample ahead of the frame must be rejected as noise.
            if (i_noise) begin
                o_line <= 1'b0;
                @(posedge i_clk);
                o_line <= 1'b1;
                repeat (7) @(posedge i_clk);
            end
            for (n = 0; n < 10; n++) begin
                b = (n == 0) ? 1'b0 : (n == 9) ? i_stop : i_char[n-1];
                o_line <= b;
                repeat (8) @(posedge i_clk);
                // One flipped clock hits only the middle vote sample.
                if (i_noise && n == 2) o_line <= ~b;
                @(posedge i_clk);
                o_line <= b;
                repeat (BIT_CLKS - 9) @(posedge i_clk);
            end
            o_line <= 1'b1;
            o_busy <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: sim/testbench.sv
// Self-checking bench for the receive front end, with a reference model.
// Assumes the transmitter model sends one bit per sixteen clocks.
`timescale 1ns/1ps
`default_nettype none
module testbench
    import rx_pkg::*;
;
    logic clk = 1'b0, rstn = 1'b0, go = 1'b0, nz = 1'b0, stp = 1'b1;
    logic awv = 1'b0, wv = 1'b0, bre = 1'b0, arv = 1'b0, rre = 1'b0;
    logic [7:0] awa = 8'h00, ara = 8'h00, ch = 8'h00, dat = 8'h00;
    logic [31:0] wd = 32'h0, rd_d;
    logic awr, wrdy, bv, arr, rv, irq, line, busy;
    logic [1:0] br, rr;
    logic [5:0] st = 6'h00, msk = 6'h00;
    int miscompares = 0, n_checks = 0, cyc = 0;
    localparam logic [6:0] SLP = 7'h08, CLR = 7'h7D;
    localparam logic [6:0] STP = 7'h4F, ZRO = 7'h20;

    always #12.5 clk = ~clk;

    rx_front u_dut (.I_REF_CLK(clk), .I_RSTN(rstn), .I_RXD(line),
        .I_AWVALID(awv), .O_AWREADY(awr), .I_AWADDR(awa), .I_WVALID(wv),
        .O_WREADY(wrdy), .I_WDATA(wd), .I_WSTRB(4'hF), .O_BVALID(bv),
        .I_BREADY(bre), .O_BRESP(br), .I_ARVALID(arv), .O_ARREADY(arr),
        .I_ARADDR(ara), .O_RVALID(rv), .I_RREADY(rre), .O_RDATA(rd_d),
        .O_RRESP(rr), .O_IRQ(irq));
    rx_line_src u_src (.i_clk(clk), .i_go(go), .i_char(ch), .i_stop(stp),
        .i_noise(nz), .o_line(line), .o_busy(busy));

    // ------------------------------------------------------------------
    // Comparison, bus cycles and closing report
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, g);
        n_checks++;
        if (g !== e) begin
            miscompares++;
            $display("wrong value %s exp %0h got %0h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        logic ta, tw;
        ta = 1'b0;
        tw = 1'b0;
        awv <= 1'b1;
        awa <= a;
        wv <= 1'b1;
        wd <= d;
        bre <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge clk);
            if (awr && !ta) begin
                ta = 1'b1;
                awv <= 1'b0;
            end
            if (wrdy && !tw) begin
                tw = 1'b1;
                wv <= 1'b0;
            end
        end
        do @(posedge clk); while (!bv);
        bre <= 1'b0;
        chk("bresp", er, br);
        // Let an edge pass so a following call never rewrites ready at once.
        @(posedge clk);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e,
                      input logic [1:0] er);
        arv <= 1'b1;
        ara <= a;
        rre <= 1'b1;
        do @(posedge clk); while (!arr);
        arv <= 1'b0;
        do @(posedge clk); while (!rv);
        rre <= 1'b0;
        chk("rdata", e, rd_d);
        chk("rresp", er, rr);
        @(posedge clk);
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // A hang would otherwise stall the run; the tests need about 2800.
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        int i;
        void'($urandom(32'h0A15D8C7));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk("irq", 0, irq);
        rd(REG_CTRL, {30'h0, CTL_RESET}, RESP_OKAY);
        rd(REG_DIV, {16'h0, DIV_RESET}, RESP_OKAY);
        rd(REG_STATUS, 0, RESP_OKAY);
        rd(8'h18, 0, RESP_SLVERR);
        wr(8'h1C, 32'h1, RESP_SLVERR);
        wr(REG_DATA, 32'hFF, RESP_OKAY);
        rd(REG_DATA, 0, RESP_OKAY);
        wr(REG_DIV, 32'h1, RESP_OKAY);
        rd(REG_DIV, 32'h1, RESP_OKAY);
        rd(REG_STATE, 32'h00010001, RESP_OKAY);
        $display("register test done");
        for (i = 0; i < 7; i++) begin
            ch <= ZRO[i] ? 8'h00 : 8'($urandom);
            stp <= STP[i];
            nz <= 1'($urandom);
            msk = 6'($urandom);
            wr(REG_CTRL, {30'h0, SLP[i], 1'b1}, RESP_OKAY);
            wr(REG_MASK, {26'h0, msk}, RESP_OKAY);
            if (CLR[i]) begin
                wr(REG_STATUS, 32'h3F, RESP_OKAY);
                st = 6'h00;
            end
            go <= 1'b1;
            @(posedge clk);
            go <= 1'b0;
            @(posedge clk);
            while (busy) @(posedge clk);
            repeat (200) @(posedge clk);
            if (!SLP[i]) begin
                st[FL_IDLE] = 1'b1;
                if (st[FL_FULL]) st[FL_OVR] = 1'b1;
                else begin
                    st[FL_FULL] = 1'b1;
                    dat = ch;
                    st[FL_NOISE] |= nz;
                    st[FL_FE] |= !stp;
                    st[FL_BRK] |= !stp && ch == 8'h00;
                end
            end
            rd(REG_DATA, {24'h0, dat}, RESP_OKAY);
            rd(REG_STATUS, {26'h0, st}, RESP_OKAY);
            rd(REG_STATE, 32'h00010001, RESP_OKAY);
            chk("irq", |(st & msk), irq);
            $display("frame case %0d done", i);
        end
        end_of_test();
    end
endmodule
`default_nettype wire
